// file: trl_pkg.sv
/*
  constants shared by the timer read-back / status-latch block.
  assumes a single 100 MHz clock domain and a plain register port.
*/
package trl_pkg;
  // ****************************************************************
  // register addresses (two-bit port address)
  // ****************************************************************
  localparam logic [1:0] TRL_ADDR_CNT0 = 2'h0;  // counter 0 data
  localparam logic [1:0] TRL_ADDR_CNT1 = 2'h1;  // counter 1 data
  localparam logic [1:0] TRL_ADDR_CNT2 = 2'h2;  // counter 2 data
  localparam logic [1:0] TRL_ADDR_CTRL = 2'h3;  // control word
  // ****************************************************************
  // control word fields
  // ****************************************************************
  localparam int TRL_CW_SEL_HI  = 7;  // counter select / read-back code
  localparam int TRL_CW_SEL_LO  = 6;
  localparam int TRL_CW_RW_HI   = 5;  // byte_access_sel_hi
  localparam int TRL_CW_RW_LO   = 4;  // byte_access_sel_lo
  localparam int TRL_RB_CNT_N   = 5;  // count latch, active low
  localparam int TRL_RB_STS_N   = 4;  // status latch, active low
  localparam int TRL_RB_SEL0    = 1;  // counter 0 select, 1..3 map 0..2
  localparam int TRL_RB_ZERO    = 0;  // must be zero
  localparam logic [1:0] TRL_SEL_RB    = 2'h3;  // read-back code
  localparam logic [1:0] TRL_RW_LATCH  = 2'h0;  // counter latch command
  localparam logic [1:0] TRL_RW_LSB    = 2'h1;
  localparam logic [1:0] TRL_RW_MSB    = 2'h2;
  localparam logic [1:0] TRL_RW_WORD   = 2'h3;
  localparam int TRL_STS_OUT    = 7;  // status byte: output level
  localparam int TRL_STS_PEND   = 6;  // status byte: pending-load flag
  localparam logic [5:0] TRL_MODE_RST = 6'h00;  // mode bits after reset
  localparam int TRL_NCH = 3;  // counters served
  // read sequencer states, gray along the usual path
  typedef enum logic [1:0] {
    TRL_RD_LO = 2'b00,  // next read is low byte
    TRL_RD_HI = 2'b01   // next read is high byte
  } trl_rd_t;
endpackage : trl_pkg

// file: trl_chan.sv
/*
  one counter's pending-load flag, capture latches and read sequencing.
  assumes strobes are one-cycle pulses from the same clock domain.
*/
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module trl_chan
  import trl_pkg::*;
(
  input  wire logic        clk_i,       // system clock
  input  wire logic        rst_n_i,     // async reset, active low
  input  wire logic        cw_wr_i,     // control word for this counter
  input  wire logic [5:0]  cw_mode_i,   // access + mode bits of that word
  input  wire logic        data_wr_i,   // holding register byte write
  input  wire logic        load_i,      // holding value moved to counter
  input  wire logic        cnt_lat_i,   // count latch request
  input  wire logic        sts_lat_i,   // status latch request
  input  wire logic        out_lvl_i,   // counter output level
  input  wire logic [15:0] count_i,     // live count
  input  wire logic        rd_i,        // read of this counter
  output logic [7:0]       rd_data_o,   // byte returned for this read
  output logic             pend_o       // pending-load flag
);
  import trl_pkg::*;
  // ****************************************************************
  // state
  // ****************************************************************
  logic        pend_reg;      // pending-load flag
  logic [5:0]  mode_reg;      // last programmed access + mode
  logic        wbyte_reg;     // never driven; the word write byte phase is kept in wrh_reg
  logic        cnt_v_reg;     // count captured, unread
  logic [15:0] cnt_reg;       // captured count
  logic        sts_v_reg;     // status captured, unread
  logic [7:0]  sts_reg;       // captured status
  trl_rd_t     rdph_reg;      // byte phase of count reads
  logic        wrh_reg;       // write byte phase for word format
  // ****************************************************************
  // decode
  // ****************************************************************
  wire [1:0] acc       = mode_reg[5:4];
  wire       word_fmt  = (acc == TRL_RW_WORD);
  wire       wr_done   = data_wr_i && (!word_fmt || wrh_reg);
  wire       pend_set  = cw_wr_i || wr_done;
  wire       hi_now    = (acc == TRL_RW_MSB) || (word_fmt && rdph_reg == TRL_RD_HI);
  wire [15:0] cnt_src  = cnt_v_reg ? cnt_reg : count_i;
  wire [7:0] cnt_byte  = hi_now ? cnt_src[15:8] : cnt_src[7:0];
  wire       rd_sts    = rd_i && sts_v_reg;
  wire       rd_cnt    = rd_i && !sts_v_reg;
  wire       cnt_last  = rd_cnt && (!word_fmt || rdph_reg == TRL_RD_HI);
  wire [7:0] sts_now   = {out_lvl_i, pend_reg, mode_reg};
  // ****************************************************************
  // registers
  // ****************************************************************
  // pending flag: set wins over a same-cycle load
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_reg <= 1'b0;
    end else if (pend_set) begin
      pend_reg <= 1'b1;
    end else if (load_i) begin
      pend_reg <= 1'b0;
    end
  end
  // mode and write byte phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= TRL_MODE_RST;
      wrh_reg  <= 1'b0;
    end else if (cw_wr_i) begin
      mode_reg <= cw_mode_i;
      wrh_reg  <= 1'b0;
    end else if (data_wr_i && word_fmt) begin
      wrh_reg  <= !wrh_reg;
    end
  end
  // count capture; first request holds until fully read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_v_reg <= 1'b0;
      cnt_reg   <= 16'h0000;
    end else if (cw_wr_i) begin
      cnt_v_reg <= 1'b0;  // new control word drops a held count
    end else if (cnt_lat_i && !cnt_v_reg) begin
      cnt_v_reg <= 1'b1;
      cnt_reg   <= count_i;
    end else if (cnt_last) begin
      cnt_v_reg <= 1'b0;
    end
  end
  // status capture; first request wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sts_v_reg <= 1'b0;
      sts_reg   <= 8'h00;
    end else if (sts_lat_i && !sts_v_reg) begin
      sts_v_reg <= 1'b1;
      sts_reg   <= sts_now;
    end else if (rd_sts) begin
      sts_v_reg <= 1'b0;
    end
  end
  // read byte phase; the byte itself is registered once, at the top
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdph_reg <= TRL_RD_LO;
    end else if (cw_wr_i) begin
      rdph_reg <= TRL_RD_LO;
    end else if (rd_cnt && word_fmt) begin
      rdph_reg <= (rdph_reg == TRL_RD_LO) ? TRL_RD_HI : TRL_RD_LO;
    end
  end
  // byte this read returns: held status first, then count bytes
  assign rd_data_o = sts_v_reg ? sts_reg : cnt_byte;
  assign pend_o = pend_reg;
  // ****************************************************************
  // checks
  // ****************************************************************
  chk_pend_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pend_set |=> pend_reg) else $error("pending flag not set");
  chk_pend_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (load_i && !pend_set) |=> !pend_reg) else $error("pending flag not cleared");
  chk_word_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (data_wr_i && word_fmt && !wrh_reg && !cw_wr_i && !pend_reg && !load_i)
      |=> !pend_reg) else $error("flag set on first byte");
  chk_sts_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sts_v_reg && !rd_i) |=> (sts_v_reg && $stable(sts_reg)))
    else $error("held status changed");
  chk_cnt_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt_v_reg && !rd_i && !cw_wr_i) |=> (cnt_v_reg && $stable(cnt_reg)))
    else $error("held count changed");
  chk_sts_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sts_v_reg && cnt_v_reg) |-> (rd_data_o == sts_reg) ##1 (cnt_v_reg && !sts_v_reg))
    else $error("status not returned first");
  chk_sts_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sts_lat_i && !sts_v_reg) |=> (sts_reg == {$past(out_lvl_i), $past(pend_reg),
    $past(mode_reg)})) else $error("status capture wrong");
  chk_sts_rel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sts_v_reg && !sts_lat_i) |=> !sts_v_reg)
    else $error("status latch not released");
endmodule : trl_chan

// file: timer_readback_status_latch.sv
/*
  top of the read-back / status-latch block: command decode and read mux.
  assumes bus strobes and counter events are synchronous to clk_i.
*/
`timescale 1ns/1ps
module trl_readback_top
  import trl_pkg::*;
#(
  parameter int NCH = TRL_NCH  // counters served
)(
  input  wire logic             clk_i,      // 100 MHz clock
  input  wire logic             rst_n_i,    // async reset, active low
  input  wire logic [1:0]       addr_i,     // register address
  input  wire logic [7:0]       wdata_i,    // write data
  input  wire logic             wr_i,       // write strobe
  input  wire logic             rd_i,       // read strobe
  input  wire logic [NCH-1:0]   load_i,     // per counter holding-to-counter load
  input  wire logic [NCH-1:0]   out_lvl_i,  // per counter output level
  input  wire logic [16*NCH-1:0] count_i,   // per counter live count
  output logic [7:0]            rdata_o,    // read data, cycle after rd_i
  output logic [NCH-1:0]        pend_o      // pending-load flags
);
  import trl_pkg::*;
  if (NCH != TRL_NCH) begin : g_bad
    $error("only three counters supported");
  end
  // ****************************************************************
  // command decode
  // ****************************************************************
  wire        ctrl_wr  = wr_i && (addr_i == TRL_ADDR_CTRL);
  wire        is_rb    = wdata_i[TRL_CW_SEL_HI:TRL_CW_SEL_LO] == TRL_SEL_RB;
  wire        rb_ok    = ctrl_wr && is_rb && !wdata_i[TRL_RB_ZERO];
  wire        is_latch = wdata_i[TRL_CW_RW_HI:TRL_CW_RW_LO] == TRL_RW_LATCH;
  wire [1:0]  cw_sel   = wdata_i[TRL_CW_SEL_HI:TRL_CW_SEL_LO];
  logic [7:0] rdata_reg;  // returned byte, launched by rd_i
  logic [NCH-1:0] pend_w;
  logic [7:0] byte_w [NCH];
  // ****************************************************************
  // per counter
  // ****************************************************************
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    wire sel_rb = rb_ok && wdata_i[TRL_RB_SEL0 + g];
    wire sel_cw = ctrl_wr && !is_rb && (cw_sel == 2'(g));
    trl_chan u_ch (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .cw_wr_i   (sel_cw && !is_latch),
      .cw_mode_i (wdata_i[TRL_CW_RW_HI:0]),
      .data_wr_i (wr_i && addr_i == 2'(g)),
      .load_i    (load_i[g]),
      .cnt_lat_i ((sel_rb && !wdata_i[TRL_RB_CNT_N]) || (sel_cw && is_latch)),
      .sts_lat_i (sel_rb && !wdata_i[TRL_RB_STS_N]),
      .out_lvl_i (out_lvl_i[g]),
      .count_i   (count_i[16*g +: 16]),
      .rd_i      (rd_i && addr_i == 2'(g)),
      .rd_data_o (byte_w[g]),
      .pend_o    (pend_w[g])
    );
  end
  // ****************************************************************
  // outputs
  // ****************************************************************
  // read mux; control address reads as zero
  wire       rd_chan = (addr_i != TRL_ADDR_CTRL);
  wire [7:0] rd_byte = rd_chan ? byte_w[addr_i] : 8'h00;
  // registered here so rdata_o comes straight from a flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      rdata_reg <= rd_byte;
    end
  end
  assign rdata_o = rdata_reg;
  assign pend_o = pend_w;
endmodule : trl_readback_top

// file: trl_host_model.sv
/*
  host processor model: drives the register port of the read-back block.
  assumes one clock; signals change by non-blocking assignment after clk_i rises.
*/
`timescale 1ns/1ps
module trl_host_model
  import trl_pkg::*;
(
  input  wire logic       clk_i,    // system clock
  input  wire logic [7:0] rdata_i,  // read data, cycle after rd_o
  output logic      [1:0] addr_o,   // register address
  output logic      [7:0] wdata_o,  // write data
  output logic            wr_o,     // write strobe
  output logic            rd_o      // read strobe
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    addr_o = 2'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one-cycle write; returns at the edge that takes it
  task automatic wr_cyc(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask : wr_cyc
  // one-cycle read; data taken 1 ns after the edge that registers it
  task automatic rd_cyc(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask : rd_cyc
  // read-back command; bad only set by a refusal scenario
  task automatic rb_cmd(input logic cnt_n, input logic sts_n, input logic [2:0] sel,
                        input logic bad);
    wr_cyc(TRL_ADDR_CTRL, {TRL_SEL_RB, cnt_n, sts_n, sel, bad});
  endtask : rb_cmd
endmodule : trl_host_model

// file: timer_readback_status_latch_tb_top.sv
/*
  self-checking bench for the read-back / status-latch block.
  assumes trl_pkg, trl_readback_top and trl_host_model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module timer_readback_status_latch_tb_top;
  import trl_pkg::*;
  logic        clk_i, rst_n_i;         // clock, reset
  logic [1:0]  addr;                   // host address
  logic [7:0]  wdata, rdata, d;        // bus data
  logic        wr, rd;                 // strobes
  logic [2:0]  load_i, out_lvl_i;      // counter side
  logic [2:0]  pend_o, ep;             // flags seen / expected
  logic [47:0] count_i;                // live counts
  logic [15:0] cv;                     // latched count expected
  logic [15:0] c1, c2;                 // counts frozen by a multi latch
  logic [5:0]  md [3];                 // mode of each counter
  logic        ov;                     // output level at latch
  int          fails = 0;
  int          n_compared = 0;
  logic [31:0] seed = 32'hAFA91715;
  // ****************************************
  // harness
  // ****************************************
  trl_readback_top #(.NCH(3)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .load_i(load_i), .out_lvl_i(out_lvl_i),
    .count_i(count_i), .rdata_o(rdata), .pend_o(pend_o));
  trl_host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // xorshift stream, fixed seed so runs repeat
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // expected status byte
  function automatic logic [7:0] sts(logic o, logic p, logic [5:0] m);
    return {o, p, m};
  endfunction : sts
  // one-cycle holding-to-counter load pulse
  task automatic pulse_load(input int g);
    @(posedge clk_i);
    load_i <= 3'h1 << g;
    @(posedge clk_i);
    load_i <= 3'h0;
    #1;
  endtask : pulse_load
  // new live count and output level, launched on an edge
  task automatic set_live(input int g, input logic [15:0] c, input logic o);
    @(posedge clk_i);
    count_i[16*g +: 16] <= c;
    out_lvl_i[g] <= o;
  endtask : set_live
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  // watchdog, far beyond the 150 or so cycles the tests need
  initial begin
    #200000;
    fails++;
    summarize();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    load_i = 3'h0;
    out_lvl_i = 3'h0;
    count_i = '0;
    rst_n_i = 1'b0;
    ep = 3'h0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 `CHK("pend_rst", ep, pend_o)
    for (int g = 0; g < 3; g++) begin
      md[g] = 6'h30 | (xs() & 6'h0E);  // word access, random mode
      u_host.wr_cyc(TRL_ADDR_CTRL, {g[1:0], md[g]});
      ep[g] = 1'b1;
      #1 `CHK("pend_cw", ep, pend_o)
      pulse_load(g);
      ep[g] = 1'b0;
      `CHK("pend_load", ep, pend_o)
      u_host.wr_cyc(g[1:0], xs());
      #1 `CHK("pend_lo", ep, pend_o)
      u_host.wr_cyc(g[1:0], xs());
      ep[g] = 1'b1;
      #1 `CHK("pend_hi", ep, pend_o)
      pulse_load(g);
      ep[g] = 1'b0;
      cv = xs();
      ov = xs() & 1;
      set_live(g, cv, ov);
      u_host.rb_cmd(1'b0, 1'b0, 3'h1 << g, 1'b0);
      set_live(g, ~cv, ~ov);
      u_host.wr_cyc(g[1:0], xs());
      u_host.wr_cyc(g[1:0], xs());
      ep[g] = 1'b1;
      u_host.rb_cmd(1'b0, 1'b0, 3'h1 << g, 1'b0);
      u_host.rd_cyc(g[1:0], d);
      `CHK("status", sts(ov, 1'b0, md[g]), d)
      u_host.rd_cyc(g[1:0], d);
      `CHK("cnt_lo", cv[7:0], d)
      u_host.rd_cyc(g[1:0], d);
      `CHK("cnt_hi", cv[15:8], d)
      u_host.rd_cyc(g[1:0], d);
      `CHK("live_lo", ~cv[7:0], d)
      u_host.rd_cyc(g[1:0], d);
      $display("test latch counter %0d done", g);
    end
    cv = xs();
    set_live(0, cv, 1'b1);
    u_host.rb_cmd(1'b0, 1'b1, 3'h1, 1'b0);
    set_live(0, ~cv, 1'b0);
    u_host.rb_cmd(1'b1, 1'b0, 3'h1, 1'b0);
    u_host.rd_cyc(2'h0, d);
    `CHK("sts_first", sts(1'b0, ep[0], md[0]), d)
    u_host.rd_cyc(2'h0, d);
    `CHK("cnt_after_lo", cv[7:0], d)
    u_host.rd_cyc(2'h0, d);
    `CHK("cnt_after_hi", cv[15:8], d)
    $display("test latch order done");
    c1 = count_i[31:16];  // live values the latch must freeze
    c2 = count_i[47:32];
    u_host.rb_cmd(1'b0, 1'b1, 3'h6, 1'b0);
    set_live(1, xs(), 1'b0);
    set_live(2, xs(), 1'b0);
    u_host.rd_cyc(2'h1, d);
    `CHK("c1_held_lo", c1[7:0], d)
    u_host.rd_cyc(2'h1, d);
    `CHK("c1_held_hi", c1[15:8], d)
    u_host.rd_cyc(2'h2, d);
    `CHK("c2_held_lo", c2[7:0], d)
    u_host.rd_cyc(2'h2, d);
    `CHK("c2_held_hi", c2[15:8], d)
    u_host.rb_cmd(1'b0, 1'b0, 3'h1, 1'b1);
    u_host.rd_cyc(2'h0, d);
    `CHK("refused_rb", ~cv[7:0], d)
    $display("test multi latch and refusal done");
    md[1] = 6'h10 | (xs() & 6'h0E);  // low byte only format
    u_host.wr_cyc(TRL_ADDR_CTRL, {2'h1, md[1]});
    pulse_load(1);
    ep[1] = 1'b0;
    `CHK("pend_lsb_load", ep, pend_o)
    u_host.wr_cyc(2'h1, xs());
    ep[1] = 1'b1;
    #1 `CHK("pend_lsb", ep, pend_o)
    cv = xs();
    set_live(1, cv, 1'b0);
    u_host.wr_cyc(TRL_ADDR_CTRL, {2'h1, TRL_RW_LATCH, 4'h0});  // counter latch command
    set_live(1, ~cv, 1'b0);
    u_host.rd_cyc(2'h1, d);
    `CHK("latch_cmd_lo", cv[7:0], d)
    u_host.rd_cyc(2'h1, d);
    `CHK("latch_cmd_live", ~cv[7:0], d)
    md[2] = 6'h20 | (xs() & 6'h0E);  // high byte only format
    u_host.wr_cyc(TRL_ADDR_CTRL, {2'h2, md[2]});
    cv = xs();
    set_live(2, cv, 1'b1);
    u_host.rb_cmd(1'b0, 1'b0, 3'h4, 1'b0);
    set_live(2, ~cv, 1'b0);
    u_host.rd_cyc(2'h2, d);
    `CHK("msb_status", sts(1'b1, 1'b1, md[2]), d)
    u_host.rd_cyc(2'h2, d);
    `CHK("msb_cnt", cv[15:8], d)
    u_host.rd_cyc(TRL_ADDR_CTRL, d);
    `CHK("ctrl_rd", 8'h00, d)
    $display("test byte formats done");
    summarize();
  end
endmodule : timer_readback_status_latch_tb_top
